// file: inc/pvic_consts.svh
// Purpose: Shared constants of the vectored interrupt controller
// Assumes: 8-bit register port, 250 MHz core clock
// Notes: Flag vector index = register number * 8 + bit position
`ifndef PVIC_CONSTS_SVH
`define PVIC_CONSTS_SVH

// Register addresses
`define PVIC_ADDR_CLR0 8'hda
`define PVIC_ADDR_CLR1 8'hdb
`define PVIC_ADDR_CLR2 8'hdc
`define PVIC_ADDR_MSK3 8'hde
`define PVIC_ADDR_MSK2 8'hdf
`define PVIC_ADDR_MSK0 8'he0
`define PVIC_ADDR_MSK1 8'he1
`define PVIC_REG_RESET 8'h00
`define PVIC_MSK2_USED 8'h7f
`define PVIC_SOFT_POST_BIT 7

// Flag vector layout
`define PVIC_NUM_BITS 24
`define PVIC_LVL_NONE 5'h1f
`define PVIC_BIT2LVL '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd7, 5'd25, 5'd6, \
  5'd8, 5'd9, 5'd10, 5'd11, 5'd12, 5'd13, 5'd14, 5'd15, \
  5'd16, 5'd17, 5'd18, 5'd19, 5'd20, 5'd21, 5'd0, 5'd0}
`define PVIC_BIT_USB 12
`define PVIC_BIT_PS2 19
`define PVIC_GPIO_BITS '{4, 7, 20, 21}

// Dispatch sequence, in cycles after the start edge
`define PVIC_DISP_CYCLES 13
`define PVIC_CYC_PCH 4'h1
`define PVIC_CYC_PCL 4'h3
`define PVIC_CYC_FLG 4'h5
`define PVIC_CYC_CLR 4'h7

// PS/2 data-low filter timing
`define PVIC_CLK_HZ 250000000
`define PVIC_SLOW_HZ 32000
`define PVIC_SLOW_DIV (`PVIC_CLK_HZ / `PVIC_SLOW_HZ)
`define PVIC_PS2_LOW_PERIODS 6

`endif

// file: inc/pvic_pkg.sv
// Purpose: Types of the vectored interrupt controller
// Assumes: Constants come from pvic_consts.svh
// Notes: Dispatch states are Gray coded along idle, save, load
package pvic_pkg;
  typedef enum logic [1:0] {
    pvic_st_idle = 2'b00,
    pvic_st_save = 2'b01,
    pvic_st_load = 2'b11
  } pvic_disp_state_t;
  typedef logic [4:0] pvic_level_t;
endpackage : pvic_pkg

// file: inc/pvic_disp_if.sv
// Purpose: Link between arbitration and the dispatch sequencer
// Assumes: One clock domain
// Notes: start is a one-cycle pulse, busy is a registered level
`timescale 1ns/1ps
interface pvic_disp_if;
  logic start;
  pvic_pkg::pvic_level_t win_lvl;
  logic busy;
  modport ctl (output start, output win_lvl, input busy);
  modport seq (input start, input win_lvl, output busy);
endinterface : pvic_disp_if

// file: hdl/pvic_src_flag.sv
// Purpose: One posted-interrupt flag
// Assumes: Set and clear are one-cycle pulses
// Notes: A set in the same cycle as a clear wins
`timescale 1ns/1ps
module pvic_src_flag (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  // Posting beats clearing so an event is never lost
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end
endmodule : pvic_src_flag

// file: hdl/pvic_dispatch.sv
// Purpose: Thirteen-cycle interrupt dispatch sequencer
// Assumes: Core stalls while busy and performs pushes and loads
// Notes: Each action is a registered one-cycle pulse
`timescale 1ns/1ps
`include "pvic_consts.svh"
module pvic_dispatch (
  input wire logic i_clock,
  input wire logic i_resetn,
  pvic_disp_if.seq disp,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_flags,
  output logic o_push_valid,
  output logic [7:0] o_push_data,
  output logic o_flags_clear,
  output logic o_pc_load,
  output logic [15:0] o_pc_value
);
  pvic_pkg::pvic_disp_state_t state_r;
  logic [3:0] cnt_r;
  logic [15:0] pc_r;
  logic [7:0] flags_r;
  pvic_pkg::pvic_level_t lvl_r;

  // Sequencer: busy spans exactly the dispatch window
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= pvic_pkg::pvic_st_idle;
      cnt_r <= 4'h0;
      disp.busy <= 1'b0;
    end else begin
      case (state_r)
        pvic_pkg::pvic_st_idle: begin
          cnt_r <= 4'h0;
          if (disp.start) begin
            state_r <= pvic_pkg::pvic_st_save;
            disp.busy <= 1'b1;
          end
        end
        pvic_pkg::pvic_st_save: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `PVIC_CYC_CLR) state_r <= pvic_pkg::pvic_st_load;
        end
        pvic_pkg::pvic_st_load: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(`PVIC_DISP_CYCLES - 1)) begin
            state_r <= pvic_pkg::pvic_st_idle;
            disp.busy <= 1'b0;
          end
        end
        default: begin
          state_r <= pvic_pkg::pvic_st_idle;
          disp.busy <= 1'b0;
        end
      endcase
    end
  end

  // Snapshot of the interrupted context and the winner
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_r <= 16'h0000;
      flags_r <= 8'h00;
      lvl_r <= 5'h00;
    end else if (disp.start && state_r == pvic_pkg::pvic_st_idle) begin
      pc_r <= i_pc;
      flags_r <= i_flags;
      lvl_r <= disp.win_lvl;
    end
  end

  // Actions: high byte, low byte, flags, then flag clear and vector load
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_push_valid <= 1'b0;
      o_push_data <= 8'h00;
      o_flags_clear <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_value <= 16'h0000;
    end else begin
      o_push_valid <= 1'b0;
      o_flags_clear <= 1'b0;
      o_pc_load <= 1'b0;
      if (state_r == pvic_pkg::pvic_st_save) begin
        case (cnt_r)
          `PVIC_CYC_PCH: begin
            o_push_valid <= 1'b1;
            o_push_data <= pc_r[15:8];
          end
          `PVIC_CYC_PCL: begin
            o_push_valid <= 1'b1;
            o_push_data <= pc_r[7:0];
          end
          `PVIC_CYC_FLG: begin
            o_push_valid <= 1'b1;
            o_push_data <= flags_r;
          end
          `PVIC_CYC_CLR: o_flags_clear <= 1'b1;
          default: o_push_data <= o_push_data;
        endcase
      end
      if (state_r == pvic_pkg::pvic_st_load && cnt_r == 4'(`PVIC_DISP_CYCLES - 1)) begin
        o_pc_load <= 1'b1;
        o_pc_value <= {8'h00, 1'b0, lvl_r, 2'b00};
      end
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  property p_disp_len;
    $rose(disp.busy) |-> disp.busy[*8] ##1 disp.busy[*5] ##1 (!disp.busy && o_pc_load);
  endproperty
  a_disp_len: assert property (p_disp_len) else $error("dispatch not 13 cycles");
  property p_push_order;
    $rose(disp.busy) |-> ##2 (o_push_valid && o_push_data == $past(i_pc[15:8], 3))
      ##2 (o_push_valid && o_push_data == $past(i_pc[7:0], 5))
      ##2 (o_push_valid && o_push_data == $past(i_flags, 7));
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order wrong");
  property p_flags_clear;
    $rose(disp.busy) |-> ##8 o_flags_clear;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");
  property p_vector;
    $rose(disp.busy) |-> ##13 (o_pc_value == {8'h00, 1'b0, $past(disp.win_lvl, 14), 2'b00});
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");
endmodule : pvic_dispatch

// file: hdl/pvic_ctrl.sv
// Purpose: Prioritized vectored interrupt controller, top level
// Assumes: Core pulses i_instr_done at each instruction boundary
// Notes: Core stalls while o_dispatch_busy is high
// Function
// - Levels 0..25, vector four times level; 0 reset, 22..24 reserved.
// - Each source's trigger sets its own posted flag.
// - Posted flag holds until taken or cleared by software.
// - Pending means posted and mask bit set.
// - Mask clear blocks pending only; flag and posting remain.
// - Encoder picks highest pending; taken only with global enable set.
// - Activation by trigger, by mask update, or by enable rising.
// - Dispatch waits for the current instruction to finish.
// - Dispatch is 13 cycles, pushes high PC, low PC, then flags.
// - Dispatch then clears the whole flag register.
// - High PC byte zeroed, low byte loaded with the vector.
// - Return restores PC and flags, which re-enables interrupts.
// - Pending requests after return dispatch before the next instruction; here after it, as enable is still low at the return boundary.
// - USB activity posts on K state or single-ended zero.
// - PS/2 data-low posts after 6 to 7 slow periods low.
// - Port interrupts post on edges.
// - Latency: remaining instruction, 13 dispatch, 7 long jump cycles.
// - Reading clear registers shows flags; writing zero clears.
// - Soft post enable lets written ones post sources.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pvic_consts.svh"
module pvic_ctrl #(
  parameter int SLOW_DIV = `PVIC_SLOW_DIV,
  parameter int GPIO_W = 8
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [`PVIC_NUM_BITS-1:0] i_src_event,
  input wire logic i_usb_dp,
  input wire logic i_usb_dm,
  input wire logic i_ps2_ps2_serial_data_pad,
  input wire logic i_ps2_input_mode,
  input wire logic [4*GPIO_W-1:0] i_gpio,
  input wire logic i_instr_done,
  input wire logic i_global_irq_enable,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_flags,
  output logic o_dispatch_busy,
  output logic o_push_valid,
  output logic [7:0] o_push_data,
  output logic o_flags_clear,
  output logic o_pc_load,
  output logic [15:0] o_pc_value
);
  localparam int NB = `PVIC_NUM_BITS;
  localparam int DW = (SLOW_DIV > 2) ? $clog2(SLOW_DIV) : 1;
  localparam logic [4:0] BIT2LVL [0:NB-1] = `PVIC_BIT2LVL;
  localparam int GPIO_BIT [0:3] = `PVIC_GPIO_BITS;
  localparam logic [2:0] LOW_PERIODS = 3'(`PVIC_PS2_LOW_PERIODS);

  // Refuse settings the divider and port logic cannot serve
  if (SLOW_DIV < 2 || GPIO_W < 1) begin : g_bad_param
    $error("pvic_ctrl: SLOW_DIV must be >= 2 and GPIO_W >= 1");
  end

  logic [NB-1:0] mask_r;
  logic swen_r;
  logic [NB-1:0] flags;
  logic [NB-1:0] pending;
  logic [NB-1:0] hw_set;
  logic [NB-1:0] sw_set;
  logic [NB-1:0] sw_clr;
  logic [NB-1:0] take_vec;
  logic [4:0] win_bit;
  pvic_pkg::pvic_level_t win_lvl;
  logic req;
  logic usb_nonidle;
  logic [DW-1:0] div_cnt_r;
  logic tick_r;
  logic ps2_low;
  logic [2:0] low_cnt_r;
  logic ps2_post;
  logic [4*GPIO_W-1:0] gpio_prev_r;
  logic gpio_arm_r;
  logic [3:0] gpio_edge;
  logic [7:0] rdata_r;

  pvic_disp_if disp_if ();

  // Mask and soft-post enable registers
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mask_r <= {3{`PVIC_REG_RESET}};
      swen_r <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        `PVIC_ADDR_MSK0: mask_r[7:0] <= i_wdata;
        `PVIC_ADDR_MSK1: mask_r[15:8] <= i_wdata;
        `PVIC_ADDR_MSK2: mask_r[23:16] <= i_wdata & `PVIC_MSK2_USED;
        `PVIC_ADDR_MSK3: swen_r <= i_wdata[`PVIC_SOFT_POST_BIT];
        default: swen_r <= swen_r;
      endcase
    end
  end

  // Clear-register writes: zeros clear, ones post only when soft posting is on
  always_comb begin
    sw_clr = '0;
    sw_set = '0;
    if (i_wr) begin
      case (i_addr)
        `PVIC_ADDR_CLR0: begin
          sw_clr[7:0] = ~i_wdata;
          sw_set[7:0] = i_wdata & {8{swen_r}};
        end
        `PVIC_ADDR_CLR1: begin
          sw_clr[15:8] = ~i_wdata;
          sw_set[15:8] = i_wdata & {8{swen_r}};
        end
        `PVIC_ADDR_CLR2: begin
          sw_clr[23:16] = ~i_wdata;
          sw_set[23:16] = i_wdata & {8{swen_r}};
        end
        default: sw_clr = '0;
      endcase
    end
  end

  // Read port: data valid only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `PVIC_ADDR_CLR0: rdata_r <= flags[7:0];
          `PVIC_ADDR_CLR1: rdata_r <= flags[15:8];
          `PVIC_ADDR_CLR2: rdata_r <= flags[23:16];
          `PVIC_ADDR_MSK0: rdata_r <= mask_r[7:0];
          `PVIC_ADDR_MSK1: rdata_r <= mask_r[15:8];
          `PVIC_ADDR_MSK2: rdata_r <= mask_r[23:16];
          `PVIC_ADDR_MSK3: rdata_r <= {swen_r, 7'h00};
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end
  assign o_rdata = rdata_r;

  // USB lines leave idle: K has D+ high, SE0 has both low
  assign usb_nonidle = (i_usb_dp && !i_usb_dm) || (!i_usb_dp && !i_usb_dm);

  // Slow tick divider; a one-cycle enable avoids a second clock
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_cnt_r == DW'(SLOW_DIV - 1));
      div_cnt_r <= (div_cnt_r == DW'(SLOW_DIV - 1)) ? '0 : div_cnt_r + DW'(1);
    end
  end

  // Data-low filter: tick phase is unknown, so one extra tick is counted
  assign ps2_low = i_ps2_input_mode && !i_ps2_ps2_serial_data_pad;
  assign ps2_post = ps2_low && tick_r && (low_cnt_r == LOW_PERIODS);
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt_r <= 3'h0;
    end else if (!ps2_low) begin
      low_cnt_r <= 3'h0;
    end else if (tick_r && low_cnt_r <= LOW_PERIODS) begin
      low_cnt_r <= low_cnt_r + 3'h1; // Saturates, one post per low episode
    end
  end

  // Port edge detect; armed after the first sample to avoid a reset edge
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      gpio_prev_r <= '0;
      gpio_arm_r <= 1'b0;
    end else begin
      gpio_prev_r <= i_gpio;
      gpio_arm_r <= 1'b1;
    end
  end
  always_comb begin
    gpio_edge = 4'h0;
    for (int p = 0; p < 4; p++) begin
      gpio_edge[p] = gpio_arm_r &&
        (i_gpio[p*GPIO_W +: GPIO_W] != gpio_prev_r[p*GPIO_W +: GPIO_W]);
    end
  end

  // Hardware posting: generic event pulses plus the built-in triggers
  always_comb begin
    hw_set = i_src_event;
    hw_set[`PVIC_BIT_USB] = i_src_event[`PVIC_BIT_USB] | usb_nonidle;
    hw_set[`PVIC_BIT_PS2] = i_src_event[`PVIC_BIT_PS2] | ps2_post;
    for (int p = 0; p < 4; p++) begin
      hw_set[GPIO_BIT[p]] = i_src_event[GPIO_BIT[p]] | gpio_edge[p];
    end
  end

  // Posted flags; the mask never touches them
  for (genvar g = 0; g < NB; g++) begin : g_flag
    pvic_src_flag u_flag (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_set(hw_set[g] | sw_set[g]),
      .i_clear(sw_clr[g] | take_vec[g]),
      .o_flag(flags[g])
    );
  end

  assign pending = flags & mask_r;

  // Priority encoder: lowest level number wins; level 0 entries never win
  always_comb begin
    win_lvl = `PVIC_LVL_NONE;
    win_bit = 5'h00;
    req = 1'b0;
    for (int i = 0; i < NB; i++) begin
      if (pending[i] && BIT2LVL[i] != 5'h00 && BIT2LVL[i] < win_lvl) begin
        win_lvl = BIT2LVL[i];
        win_bit = 5'(i);
        req = 1'b1;
      end
    end
  end

  // Take only at an instruction boundary with global enable set; this also
  // covers mask updates, enable rising and the end of the first instruction after a return
  assign disp_if.start = req && i_global_irq_enable && i_instr_done && !disp_if.busy;
  assign disp_if.win_lvl = win_lvl;
  assign take_vec = disp_if.start ? (NB'(1) << win_bit) : '0;

  // Saved flags carry enable set, so a return re-arms the start term above
  pvic_dispatch u_dispatch (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .disp(disp_if.seq),
    .i_pc(i_pc),
    .i_flags(i_flags),
    .o_push_valid(o_push_valid),
    .o_push_data(o_push_data),
    .o_flags_clear(o_flags_clear),
    .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value)
  );
  assign o_dispatch_busy = disp_if.busy;

  // Checking helpers
  logic [31:0] low_cycles_r;
  logic lower_pending;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cycles_r <= 32'h0;
    end else begin
      low_cycles_r <= ps2_low ? low_cycles_r + 32'h1 : 32'h0;
    end
  end
  always_comb begin
    lower_pending = 1'b0;
    for (int i = 0; i < NB; i++) begin
      if (pending[i] && BIT2LVL[i] != 5'h00 && BIT2LVL[i] < disp_if.win_lvl) begin
        lower_pending = 1'b1;
      end
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  property p_hw_post;
    (hw_set != '0) |=> ((flags & $past(hw_set)) == $past(hw_set));
  endproperty
  a_hw_post: assert property (p_hw_post) else $error("post lost");
  property p_flag_hold;
    1'b1 |=> ((($past(flags) & ~flags) & ~$past(sw_clr | take_vec)) == '0);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag fell alone");
  property p_win_pending;
    disp_if.start |-> (flags[win_bit] && mask_r[win_bit]);
  endproperty
  a_win_pending: assert property (p_win_pending) else $error("masked win");
  property p_take_gate;
    $rose(o_dispatch_busy) |-> $past(i_global_irq_enable && i_instr_done);
  endproperty
  a_take_gate: assert property (p_take_gate) else $error("taken ungated");
  property p_lowest;
    disp_if.start |-> !lower_pending;
  endproperty
  a_lowest: assert property (p_lowest) else $error("not lowest level");
  property p_no_start_busy;
    o_dispatch_busy |-> !disp_if.start;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");
  property p_usb;
    (!i_usb_dm) |=> flags[`PVIC_BIT_USB];
  endproperty
  a_usb: assert property (p_usb) else $error("usb not posted");
  property p_ps2;
    ps2_post |-> (low_cycles_r >= 32'(`PVIC_PS2_LOW_PERIODS * SLOW_DIV));
  endproperty
  a_ps2: assert property (p_ps2) else $error("ps2 posted early");
  property p_gpio_level;
    ($stable(i_gpio) && $past(gpio_arm_r)) |-> (gpio_edge == 4'h0);
  endproperty
  a_gpio_level: assert property (p_gpio_level) else $error("level posted");
  property p_read;
    (i_rd && i_addr == `PVIC_ADDR_CLR1) |=> (o_rdata == $past(flags[15:8]));
  endproperty
  a_read: assert property (p_read) else $error("read mismatch");
  property p_soft_gate;
    (i_wr && i_addr == `PVIC_ADDR_CLR0 && !swen_r) |=>
      ((flags[7:0] & ~$past(flags[7:0]) & ~$past(hw_set[7:0])) == 8'h00);
  endproperty
  a_soft_gate: assert property (p_soft_gate) else $error("soft post ungated");
  // Taking, mask writes, level range and latency; a post in the take cycle still wins
  property p_take_clears;
    disp_if.start |=> ((flags & $past(take_vec) & ~$past(hw_set | sw_set)) == '0);
  endproperty
  a_take_clears: assert property (p_take_clears) else $error("taken flag kept");
  property p_mask_keeps;
    (i_wr && i_addr == `PVIC_ADDR_MSK1) |=>
      ((~flags[15:8] & $past(flags[15:8]) & ~$past(take_vec[15:8])) == 8'h00);
  endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("mask write dropped flag");
  property p_level_legal;
    disp_if.start |-> (win_lvl != 5'h00 && win_lvl <= 5'h19 &&
      !(win_lvl inside {[5'h16:5'h18]}));
  endproperty
  a_level_legal: assert property (p_level_legal) else $error("reserved level taken");
  property p_latency;
    disp_if.start |-> ##14 o_pc_load;
  endproperty
  a_latency: assert property (p_latency) else $error("vector load late");

  c_dispatch: cover property ($rose(o_dispatch_busy));
  c_soft_post: cover property (i_wr && swen_r && sw_set != '0);
  c_ps2: cover property (ps2_post);
  c_usb_post: cover property (usb_nonidle);
  c_back_to_back: cover property ($fell(o_dispatch_busy) ##[1:20] $rose(o_dispatch_busy));
endmodule : pvic_ctrl

// file: sim/pvic_core_model.sv
// Purpose: Behavioural processor core on the far side of the controller
// Assumes: Three-cycle instructions; the core stalls while dispatch is busy
// Notes: Each service routine runs five instructions, then returns
`timescale 1ns/1ps
module pvic_core_model (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_ie,
  input wire logic i_busy,
  input wire logic i_flags_clear,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  output logic o_instr_done,
  output logic o_gie,
  output logic [15:0] o_pc,
  output logic [7:0] o_flags
);
  logic [1:0] cyc_r;
  logic [2:0] isr_r;
  logic [15:0] ret_pc_r;
  logic [7:0] ret_flags_r;
  // No boundary while stalled, so the sequencer owns the core meanwhile
  assign o_instr_done = (cyc_r == 2'h2) && !i_busy;
  assign o_gie = o_flags[0];
  // Instruction cycle counter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cyc_r <= 2'h0;
    end else if (!i_busy) begin
      cyc_r <= o_instr_done ? 2'h0 : cyc_r + 2'h1;
    end
  end
  // Program flow: vector entry, routine body, return to the saved point
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pc <= 16'h1230;
    end else if (i_pc_load) begin
      o_pc <= i_pc_value;
    end else if (o_instr_done && isr_r == 3'h1) begin
      o_pc <= ret_pc_r;
    end else if (o_instr_done) begin
      o_pc <= o_pc + 16'h0001;
    end
  end
  // Routine length and return point, latched when the flags are wiped
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      isr_r <= 3'h0;
      ret_pc_r <= 16'h0000;
      ret_flags_r <= 8'h00;
    end else if (i_flags_clear) begin
      isr_r <= 3'h5;
      ret_pc_r <= o_pc;
      ret_flags_r <= o_flags;
    end else if (o_instr_done && isr_r != 3'h0) begin
      isr_r <= isr_r - 3'h1;
    end
  end
  // Flag register; no nesting, so the routine leaves the enable low
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flags <= 8'h14;
    end else if (i_flags_clear) begin
      o_flags <= 8'h00;
    end else if (o_instr_done && isr_r == 3'h1) begin
      o_flags <= ret_flags_r;
    end else if (isr_r == 3'h0) begin
      o_flags <= {o_flags[7:1], i_ie};
    end
  end
endmodule : pvic_core_model

// file: sim/prioritized_vectored_interrupt_ctrl_tb_top.sv
// Purpose: Self-checking bench for the vectored interrupt controller
// Assumes: Core model answers dispatch; slow divider shortened to 4
// Notes: Tasks other than cyc return 1 ns after an edge, so strobes never clash
`timescale 1ns/1ps
module prioritized_vectored_interrupt_ctrl_tb_top;
  localparam logic [4:0] LV [0:23] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07,
    5'h19, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
    5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h00, 5'h00};
  localparam logic [7:0] RA [0:7] = '{8'hda, 8'hdb, 8'hdc, 8'hde, 8'hdf, 8'he0,
    8'he1, 8'h55};
  localparam logic [7:0] RU [0:7] = '{8'hff, 8'hff, 8'hff, 8'h80, 8'h7f, 8'hff,
    8'hff, 8'h00};
  logic clock, resetn, wr, rd, usb_dm, usb_dp, ps2_ps2_serial_data_pad, ps2_in, ie, done, global_irq_enable;
  logic busy, push_valid, flags_clear, pc_load;
  logic [7:0] addr, wdata, rdata, push_data, flags, d;
  logic [23:0] src_event;
  logic [31:0] gpio;
  logic [15:0] pc_value, pc;
  logic [4:0] lo, hi;
  int b, b2, num_errors, samples_checked;
  pvic_ctrl #(.SLOW_DIV(4), .GPIO_W(8)) dut_u (.i_clock(clock), .i_resetn(resetn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_src_event(src_event), .i_usb_dp(usb_dp), .i_usb_dm(usb_dm),
    .i_ps2_ps2_serial_data_pad(ps2_ps2_serial_data_pad), .i_ps2_input_mode(ps2_in), .i_gpio(gpio),
    .i_instr_done(done), .i_global_irq_enable(global_irq_enable), .i_pc(pc), .i_flags(flags),
    .o_dispatch_busy(busy), .o_push_valid(push_valid), .o_push_data(push_data),
    .o_flags_clear(flags_clear), .o_pc_load(pc_load), .o_pc_value(pc_value));
  pvic_core_model core_u (.i_clock(clock), .i_resetn(resetn), .i_ie(ie),
    .i_busy(busy), .i_flags_clear(flags_clear), .i_pc_load(pc_load),
    .i_pc_value(pc_value), .o_instr_done(done), .o_gie(global_irq_enable), .o_pc(pc),
    .o_flags(flags));
  // Comparison and verdict helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Register port cycles and event pulses
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  task automatic post(input logic [23:0] m);
    src_event <= m;
    @(posedge clock);
    src_event <= 24'h000000;
    #1;
  endtask : post
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      chk(busy, 16'h0000);
    end
  endtask : quiet
  // Follows one dispatch from the busy rise to the vector load
  task automatic disp(input logic [4:0] lvl);
    logic [7:0] q [$];
    logic [15:0] pc0;
    logic [7:0] fl0;
    logic clr;
    int n;
    n = 0;
    clr = 1'b0;
    while (busy !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(16'(n < 300), 16'h0001);
    pc0 = pc - 16'h0001;
    fl0 = flags;
    for (int i = 2; i <= 14; i++) begin
      @(posedge clock);
      #1;
      if (push_valid === 1'b1) q.push_back(push_data);
      if (flags_clear === 1'b1) clr = 1'b1;
    end
    chk(16'(q.size()), 16'h0003);
    chk({q[0], q[1]}, pc0);
    chk(q[2], fl0);
    chk(clr, 16'h0001);
    chk({pc_load, busy}, 16'h0002);
    chk(pc_value, {8'h00, lvl, 2'b00});
  endtask : disp
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Bounds a hang; the full run needs under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    void'($urandom(32'h2c08cf2c));
    resetn = 1'b0;
    {wr, rd, ie, ps2_ps2_serial_data_pad, usb_dm, usb_dp, ps2_in} = 7'b0001101;
    {addr, wdata, src_event} = 40'h0;
    gpio = 32'($urandom);
    cyc(8);
    resetn <= 1'b1;
    cyc(1);
    for (int k = 0; k < 8; k++) rd_chk(RA[k], 8'h00);
    for (int k = 3; k < 7; k++) begin
      d = 8'($urandom);
      wr_reg(RA[k], d);
      rd_chk(RA[k], d & RU[k]);
      wr_reg(RA[k], 8'h00);
    end
    // Posting and clearing of random flags with every source masked
    for (int k = 0; k < 6; k++) begin
      b = $urandom % 24;
      post(24'h000001 << b);
      rd_chk(RA[b / 8], 8'h01 << (b % 8));
      wr_reg(RA[b / 8], 8'h00);
      rd_chk(RA[b / 8], 8'h00);
    end
    wr_reg(8'hda, 8'hff);
    rd_chk(8'hda, 8'h00);
    wr_reg(8'hde, 8'h80);
    d = 8'($urandom);
    wr_reg(8'hdb, d);
    rd_chk(8'hdb, d);
    wr_reg(8'hdb, 8'h00);
    wr_reg(8'hde, 8'h00);
    // A masked flag waits; enabling its mask starts dispatch
    ie <= 1'b1;
    post(24'h000200);
    quiet(30);
    rd_chk(8'hdb, 8'h02);
    wr_reg(8'he1, 8'h02);
    disp(5'h09);
    rd_chk(8'hdb, 8'h00);
    cyc(20);
    wr_reg(8'he0, 8'hff);
    wr_reg(8'he1, 8'hff);
    wr_reg(8'hdf, 8'h7f);
    // Two sources at once: gate by enable, then order by level
    for (int k = 0; k < 4; k++) begin
      ie <= 1'b0;
      b = $urandom % 22;
      b2 = (b + 1 + $urandom % 21) % 22;
      post((24'h000001 << b) | (24'h000001 << b2));
      quiet(12);
      ie <= 1'b1;
      lo = (LV[b] < LV[b2]) ? LV[b] : LV[b2];
      hi = (LV[b] < LV[b2]) ? LV[b2] : LV[b];
      disp(lo);
      disp(hi);
      cyc(20);
    end
    // Hardware trigger conditions
    usb_dm <= 1'b0;
    cyc(1);
    usb_dm <= 1'b1;
    disp(5'h0c);
    cyc(20);
    // K state: D+ high, D- low, for one cycle
    {usb_dp, usb_dm} <= 2'b10;
    cyc(1);
    {usb_dp, usb_dm} <= 2'b01;
    disp(5'h0c);
    cyc(20);
    gpio[16] <= ~gpio[16];
    disp(5'h14);
    cyc(20);
    gpio[3] <= ~gpio[3];
    disp(5'h05);
    cyc(20);
    // Data low with the pad not an input must never post
    ps2_in <= 1'b0;
    ps2_ps2_serial_data_pad <= 1'b0;
    quiet(40);
    ps2_in <= 1'b1;
    quiet(20);
    disp(5'h13);
    ps2_ps2_serial_data_pad <= 1'b1;
    cyc(30);
    finish_test();
  end
endmodule : prioritized_vectored_interrupt_ctrl_tb_top
